//--- logic/pin_mux_pkg.sv
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // Pin indices in the eight-pin vector
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 8;
  localparam int IDX_A0 = 0;
  localparam int IDX_A3 = 1;
  localparam int IDX_A4 = 2;
  localparam int IDX_A5 = 3;
  localparam int IDX_A6 = 4;
  localparam int IDX_A7 = 5;
  localparam int IDX_B6 = 6;
  localparam int IDX_B7 = 7;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_PULLUP = 8'h08;
  localparam logic [7:0] OFS_DIGIN = 8'h0C;
  localparam logic [7:0] OFS_ALTSEL = 8'h10;
  localparam logic [7:0] OFS_EDGE = 8'h14;
  localparam logic [7:0] OFS_PINSTATE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // ----------------------------------------------------------------
  // Alternate select bit positions
  // ----------------------------------------------------------------
  localparam int ALT_CRYSTAL = 0;
  localparam int ALT_EXT_RESET = 1;
  localparam int ALT_COMP_OUT = 2;
  localparam int ALT_PWM2_A3 = 3;
  localparam int ALT_PWM3_B6 = 4;
  localparam int ALT_PWM3_B7 = 5;
  localparam int ALT_IRQ1_ALT = 6;
  localparam int ALT_PULLDOWN_B6 = 7;

  // ----------------------------------------------------------------
  // Edge select and status bit positions
  // ----------------------------------------------------------------
  localparam int EDGE_IRQ0_RISE = 0;
  localparam int EDGE_IRQ0_FALL = 1;
  localparam int EDGE_IRQ1_RISE = 2;
  localparam int EDGE_IRQ1_FALL = 3;
  localparam int STAT_IRQ0 = 0;
  localparam int STAT_IRQ1 = 1;
  localparam int STAT_WAKE = 2;
  localparam int STAT_WIDTH = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_DIGIN = 8'hFF;
  localparam logic [7:0] RST_ALTSEL = 8'h00;
  localparam logic [3:0] RST_EDGE = 4'h3;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic [1:0] SYNC_SETTLE = 2'h3;

endpackage

//--- logic/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first_r;
    logic [WIDTH-1:0] second_r;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  always_comb
  begin
    st_nxt.first_r = async_in;
    st_nxt.second_r = st_r.first_r;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.second_r;

endmodule
`default_nettype wire

//--- logic/edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic level_in,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic edge_pulse
);

  typedef struct packed {
    logic prev_r;
  } edge_state_type;

  edge_state_type st_r;
  edge_state_type st_nxt;

  always_comb
  begin
    st_nxt.prev_r = level_in;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign edge_pulse = (rise_en & level_in & ~st_r.prev_r) | (fall_en & ~level_in & st_r.prev_r);

endmodule
`default_nettype wire

//--- logic/port_pin_function_mux.sv
// Summary of operation
// - Each general pin is a software-chosen digital input or push-pull output with optional pull-up.
// - Port A bit 5 is input or open-drain output with pull-up, or else the hardware reset input.
// - A cleared digital-input-enable bit turns off the input buffer and blocks wake-up from that pin.
// - Port A bits 7 and 6 carry crystal in and out while the crystal is selected.
// - Clearing port A bit 0 input enable stops that pin waking the device from power-down.
// - Interrupt pins port A bit 0 and bit 4 request on rising or falling edges chosen by register.
// - Port A bit 4 may replace the primary pin as source of external interrupt line one.
// - Comparator inputs come from A4, A3, B6, B7, and A0 carries the comparator output.
// - ADC channels 9, 8, 10, 7 and 6 come from A4, A3, A0, B7 and B6.
// - Port A bit 3 can output timer two PWM and port B bits 7 and 6 timer three PWM.
// - Port B bit 6 offers a selectable pull-down as well as the pull-up.
`timescale 1ns/10ps
`default_nettype none
module port_pin_function_mux (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  output logic pulldown_b6,
  output logic [7:0] input_buf_en,
  input wire logic comparator_out,
  input wire logic timer_two_pwm_out,
  input wire logic timer_three_pwm_out,
  output logic crystal_sel,
  output logic crystal_in_pin,
  output logic crystal_out_en,
  output logic external_reset_pin,
  output logic ext_irq_line_zero,
  output logic ext_irq_line_one_alt,
  output logic [2:0] ext_irq_edge,
  output logic [4:0] adc_input_sel,
  output logic [5:0] comparator_route_sel,
  input wire logic sleep_mode,
  output logic wake_request,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data_r;
    logic [7:0] dir_r;
    logic [7:0] pullup_r;
    logic [7:0] digin_r;
    logic [7:0] altsel_r;
    logic [3:0] edge_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [7:0] prev_pins_r;
    logic [1:0] warm_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [1:0] bresp_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
  } mux_state_type;

  mux_state_type st_r;
  mux_state_type st_nxt;
  logic [7:0] pins_sync;
  logic [7:0] pins_gated;
  logic irq0_edge;
  logic irq1_edge;
  logic irq1_src;
  logic wake_edge;
  logic wr_go;
  logic rd_go;

  pin_sync #(
    .WIDTH(pin_mux_pkg::PIN_COUNT)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // Input gating and interrupt edges
  // ----------------------------------------------------------------
  assign pins_gated = pins_sync & st_r.digin_r;
  assign irq1_src = pins_gated[pin_mux_pkg::IDX_A4];

  edge_detect u_edge0 (
    .clk(clk),
    .rst(rst),
    .level_in(pins_gated[pin_mux_pkg::IDX_A0]),
    .rise_en(st_r.edge_r[pin_mux_pkg::EDGE_IRQ0_RISE]),
    .fall_en(st_r.edge_r[pin_mux_pkg::EDGE_IRQ0_FALL]),
    .edge_pulse(irq0_edge)
  );

  edge_detect u_edge1 (
    .clk(clk),
    .rst(rst),
    .level_in(irq1_src),
    .rise_en(st_r.edge_r[pin_mux_pkg::EDGE_IRQ1_RISE]),
    .fall_en(st_r.edge_r[pin_mux_pkg::EDGE_IRQ1_FALL]),
    .edge_pulse(irq1_edge)
  );

  // Wake only from pins whose input buffer is on; toggling a gated pin is invisible
  assign wake_edge = sleep_mode && ((pins_gated ^ st_r.prev_pins_r) != 8'h00);
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid_r;
  assign rd_go = s_axi_arvalid && !st_r.rvalid_r;

  // ----------------------------------------------------------------
  // Register file and bus
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] wa;
    logic [7:0] ra;
    logic [2:0] events;
    wa = s_axi_awaddr[7:0];
    ra = s_axi_araddr[7:0];
    st_nxt = st_r;
    st_nxt.prev_pins_r = pins_gated;
    events = 3'h0;
    events[pin_mux_pkg::STAT_IRQ0] = irq0_edge;
    events[pin_mux_pkg::STAT_IRQ1] = irq1_edge & st_r.altsel_r[pin_mux_pkg::ALT_IRQ1_ALT];
    events[pin_mux_pkg::STAT_WAKE] = wake_edge;
    // Synchroniser reads 0 until it fills, so a pad held high would look like a fresh edge
    if (st_r.warm_r != pin_mux_pkg::SYNC_SETTLE)
    begin
      st_nxt.warm_r = st_r.warm_r + 2'h1;
      events = 3'h0;
    end
    if (st_r.bvalid_r && s_axi_bready)
    begin
      st_nxt.bvalid_r = 1'b0;
    end
    if (st_r.rvalid_r && s_axi_rready)
    begin
      st_nxt.rvalid_r = 1'b0;
    end
    if (wr_go)
    begin
      st_nxt.bvalid_r = 1'b1;
      st_nxt.bresp_r = 2'h0;
      if (s_axi_wstrb[0])
      begin
        unique case (wa)
          pin_mux_pkg::OFS_DATA: st_nxt.data_r = s_axi_wdata[7:0];
          pin_mux_pkg::OFS_DIR: st_nxt.dir_r = s_axi_wdata[7:0];
          pin_mux_pkg::OFS_PULLUP: st_nxt.pullup_r = s_axi_wdata[7:0];
          pin_mux_pkg::OFS_DIGIN: st_nxt.digin_r = s_axi_wdata[7:0];
          pin_mux_pkg::OFS_ALTSEL: st_nxt.altsel_r = s_axi_wdata[7:0];
          pin_mux_pkg::OFS_EDGE: st_nxt.edge_r = s_axi_wdata[3:0];
          pin_mux_pkg::OFS_IRQ_STATUS: st_nxt.status_r = st_r.status_r & ~s_axi_wdata[2:0];
          pin_mux_pkg::OFS_IRQ_MASK: st_nxt.mask_r = s_axi_wdata[2:0];
          pin_mux_pkg::OFS_PINSTATE: st_nxt.bresp_r = 2'h0;
          default: st_nxt.bresp_r = 2'h2;
        endcase
      end
    end
    // Set beats clear so an edge in the clearing cycle is kept
    st_nxt.status_r = st_nxt.status_r | events;
    if (rd_go)
    begin
      st_nxt.rvalid_r = 1'b1;
      st_nxt.rresp_r = 2'h0;
      st_nxt.rdata_r = 32'h0000_0000;
      unique case (ra)
        pin_mux_pkg::OFS_DATA: st_nxt.rdata_r[7:0] = st_r.data_r;
        pin_mux_pkg::OFS_DIR: st_nxt.rdata_r[7:0] = st_r.dir_r;
        pin_mux_pkg::OFS_PULLUP: st_nxt.rdata_r[7:0] = st_r.pullup_r;
        pin_mux_pkg::OFS_DIGIN: st_nxt.rdata_r[7:0] = st_r.digin_r;
        pin_mux_pkg::OFS_ALTSEL: st_nxt.rdata_r[7:0] = st_r.altsel_r;
        pin_mux_pkg::OFS_EDGE: st_nxt.rdata_r[3:0] = st_r.edge_r;
        pin_mux_pkg::OFS_PINSTATE: st_nxt.rdata_r[7:0] = pins_gated;
        pin_mux_pkg::OFS_IRQ_STATUS: st_nxt.rdata_r[2:0] = st_r.status_r;
        pin_mux_pkg::OFS_IRQ_MASK: st_nxt.rdata_r[2:0] = st_r.mask_r;
        default: st_nxt.rresp_r = 2'h2;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.data_r <= pin_mux_pkg::RST_DATA;
      st_r.dir_r <= pin_mux_pkg::RST_DIR;
      st_r.pullup_r <= pin_mux_pkg::RST_PULLUP;
      st_r.digin_r <= pin_mux_pkg::RST_DIGIN;
      st_r.altsel_r <= pin_mux_pkg::RST_ALTSEL;
      st_r.edge_r <= pin_mux_pkg::RST_EDGE;
      st_r.mask_r <= pin_mux_pkg::RST_MASK;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = st_r.bvalid_r;
  assign s_axi_bresp = st_r.bresp_r;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = st_r.rvalid_r;
  assign s_axi_rresp = st_r.rresp_r;
  assign s_axi_rdata = st_r.rdata_r;
  assign irq = (st_r.status_r & st_r.mask_r) != 3'h0;
  assign wake_request = st_r.status_r[pin_mux_pkg::STAT_WAKE];

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] val;
    logic [7:0] oe;
    val = st_r.data_r;
    oe = st_r.dir_r;
    if (st_r.altsel_r[pin_mux_pkg::ALT_COMP_OUT])
    begin
      val[pin_mux_pkg::IDX_A0] = comparator_out;
      oe[pin_mux_pkg::IDX_A0] = 1'b1;
    end
    if (st_r.altsel_r[pin_mux_pkg::ALT_PWM2_A3])
    begin
      val[pin_mux_pkg::IDX_A3] = timer_two_pwm_out;
      oe[pin_mux_pkg::IDX_A3] = 1'b1;
    end
    if (st_r.altsel_r[pin_mux_pkg::ALT_PWM3_B6])
    begin
      val[pin_mux_pkg::IDX_B6] = timer_three_pwm_out;
      oe[pin_mux_pkg::IDX_B6] = 1'b1;
    end
    if (st_r.altsel_r[pin_mux_pkg::ALT_PWM3_B7])
    begin
      val[pin_mux_pkg::IDX_B7] = timer_three_pwm_out;
      oe[pin_mux_pkg::IDX_B7] = 1'b1;
    end
    // Open drain: enable only while pulling low
    oe[pin_mux_pkg::IDX_A5] = st_r.dir_r[pin_mux_pkg::IDX_A5] & ~st_r.data_r[pin_mux_pkg::IDX_A5]
      & ~st_r.altsel_r[pin_mux_pkg::ALT_EXT_RESET];
    val[pin_mux_pkg::IDX_A5] = 1'b0;
    if (st_r.altsel_r[pin_mux_pkg::ALT_CRYSTAL])
    begin
      oe[pin_mux_pkg::IDX_A7] = 1'b0;
      oe[pin_mux_pkg::IDX_A6] = 1'b0;
    end
    pin_out = val;
    pin_oe = oe;
  end

  assign pin_pullup = st_r.pullup_r;
  assign pulldown_b6 = st_r.altsel_r[pin_mux_pkg::ALT_PULLDOWN_B6];
  assign input_buf_en = st_r.digin_r;
  assign crystal_sel = st_r.altsel_r[pin_mux_pkg::ALT_CRYSTAL];
  // Crystal path is analog; this only feeds the clock block with the synchronised pad level, not gated by its input enable
  assign crystal_in_pin = st_r.altsel_r[pin_mux_pkg::ALT_CRYSTAL] & pins_sync[pin_mux_pkg::IDX_A7];
  assign crystal_out_en = st_r.altsel_r[pin_mux_pkg::ALT_CRYSTAL];
  assign external_reset_pin = st_r.altsel_r[pin_mux_pkg::ALT_EXT_RESET]
    & ~pins_sync[pin_mux_pkg::IDX_A5];
  assign ext_irq_line_zero = pins_gated[pin_mux_pkg::IDX_A0];
  assign ext_irq_line_one_alt = st_r.altsel_r[pin_mux_pkg::ALT_IRQ1_ALT] & irq1_src;
  assign ext_irq_edge = {st_r.status_r[pin_mux_pkg::STAT_IRQ1],
    st_r.status_r[pin_mux_pkg::STAT_IRQ0], irq0_edge | irq1_edge};
  // ADC: {A0 ch10, A4 ch9, A3 ch8, B7 ch7, B6 ch6}, tied active when the pin is not a digital input
  assign adc_input_sel = ~{st_r.digin_r[pin_mux_pkg::IDX_A0], st_r.digin_r[pin_mux_pkg::IDX_A4],
    st_r.digin_r[pin_mux_pkg::IDX_A3], st_r.digin_r[pin_mux_pkg::IDX_B7],
    st_r.digin_r[pin_mux_pkg::IDX_B6]};
  // Comparator: {plus A4, minus0 A3, minus1 A4, minus4 B6, minus5 B7, out A0}
  assign comparator_route_sel = {~st_r.digin_r[pin_mux_pkg::IDX_A4],
    ~st_r.digin_r[pin_mux_pkg::IDX_A3], ~st_r.digin_r[pin_mux_pkg::IDX_A4],
    ~st_r.digin_r[pin_mux_pkg::IDX_B6], ~st_r.digin_r[pin_mux_pkg::IDX_B7],
    st_r.altsel_r[pin_mux_pkg::ALT_COMP_OUT]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  gated_input_off_a: assert property (!st_r.digin_r[0] |-> !pins_gated[0])
    else $error("disabled input buffer passes pin level");
  a0_wake_block_a: assert property (sleep_mode && !st_r.digin_r[0]
    && $stable(st_r.digin_r) && ((pins_gated ^ st_r.prev_pins_r) & 8'hFE) == 8'h00 |-> !wake_edge)
    else $error("wake from gated pin");
  open_drain_a5_a: assert property (pin_oe[pin_mux_pkg::IDX_A5]
    |-> !pin_out[pin_mux_pkg::IDX_A5])
    else $error("port A bit 5 drives high");
  crystal_release_a: assert property (crystal_sel |-> !pin_oe[pin_mux_pkg::IDX_A7]
    && !pin_oe[pin_mux_pkg::IDX_A6])
    else $error("crystal pins driven as port");
  comp_override_a: assert property (st_r.altsel_r[pin_mux_pkg::ALT_COMP_OUT]
    |-> pin_oe[0] && pin_out[0] == comparator_out)
    else $error("comparator output not on pin");
  pwm_b7_out_a: assert property (st_r.altsel_r[pin_mux_pkg::ALT_PWM3_B7]
    |-> pin_out[pin_mux_pkg::IDX_B7] == timer_three_pwm_out)
    else $error("timer three pwm missing");
  rise_irq0_a: assert property (st_r.edge_r[0] && $rose(pins_gated[0])
    && st_r.warm_r == pin_mux_pkg::SYNC_SETTLE |=> st_r.status_r[0])
    else $error("rising edge not latched");
  pulldown_b6_a: assert property ($past(wr_go && s_axi_wstrb[0]
    && s_axi_awaddr[7:0] == pin_mux_pkg::OFS_ALTSEL) |-> pulldown_b6 == $past(s_axi_wdata[7]))
    else $error("pull-down select lost");
  write_resp_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("no write response");

  irq0_seen_c: cover property (st_r.status_r[0] && irq);
  wake_seen_c: cover property (wake_request);
  pwm_a3_c: cover property (st_r.altsel_r[pin_mux_pkg::ALT_PWM2_A3] && s_axi_rvalid);

endmodule
`default_nettype wire

//--- test/pad_board.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------
// Board at the pads
// ----------------
module pad_board (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic pulldown_b6,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] float_r = 8'h00;

  // A pad nobody holds wanders, so a missing pull is not hidden
  always_ff @(posedge clk)
    float_r <= ~float_r;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i] && ext_en[i])
        pin_in[i] = 1'bX;
      else if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else if (i == 6 && pulldown_b6)
        pin_in[i] = 1'b0;
      else
        pin_in[i] = float_r[i];
    end
  end
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, input_buf_en, ext_en, ext_val;
  logic pulldown_b6, comparator_out, timer_two_pwm_out, timer_three_pwm_out, crystal_sel;
  logic crystal_in_pin, external_reset_pin, ext_irq_line_one_alt, sleep_mode;
  logic wake_request, irq, crystal_out_en, ext_irq_line_zero;
  logic [2:0] ext_irq_edge;
  logic [5:0] comparator_route_sel;
  logic [4:0] adc_input_sel;
  int err_count, check_count, cyc;

  port_pin_function_mux i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .pulldown_b6, .input_buf_en, .comparator_out, .timer_two_pwm_out, .timer_three_pwm_out,
    .crystal_sel, .crystal_in_pin, .crystal_out_en, .external_reset_pin,
    .ext_irq_line_zero, .ext_irq_line_one_alt, .ext_irq_edge, .adc_input_sel,
    .comparator_route_sel, .sleep_mode, .wake_request, .irq);

  pad_board i_board (.clk, .pin_out, .pin_oe, .pin_pullup, .pulldown_b6, .ext_en,
    .ext_val, .pin_in);

  // ----------------
  // Bus and check tasks
  // ----------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, where the values of the next rising edge stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      rs = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge clk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid & s_axi_rready;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask

  // Two sync flops, the status flop, one spare edge, then a settled half cycle
  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic results;
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    rc(pin_mux_pkg::OFS_DIGIN, 32'hFF);
    rc(pin_mux_pkg::OFS_DIR, 32'h00);
    rc(pin_mux_pkg::OFS_EDGE, 32'h03);
    rd(8'h40);
    chk(rs, 2'h2);
  endtask

  task automatic t_gpio;
    wr(pin_mux_pkg::OFS_PULLUP, 32'hFF);
    ext_en <= 8'h00;
    wr(pin_mux_pkg::OFS_DIR, 32'hFF);
    wr(pin_mux_pkg::OFS_DATA, 32'hA5);
    @(negedge clk);
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'hA5);
    chk(pin_pullup, 8'hFF);
    wr(pin_mux_pkg::OFS_DATA, 32'h0F);
    @(negedge clk);
    chk(pin_oe, 8'hF7);
    chk(pin_out & pin_oe, 8'h07);
    settle;
    rc(pin_mux_pkg::OFS_PINSTATE, 32'h0F);
    wr(pin_mux_pkg::OFS_DIR, 32'h00);
    ext_en <= 8'hFF;
  endtask

  task automatic t_input;
    ext_val <= 8'h5A;
    settle;
    rc(pin_mux_pkg::OFS_PINSTATE, 32'h5A);
    wr(pin_mux_pkg::OFS_DIGIN, 32'h0F);
    @(negedge clk);
    chk(input_buf_en, 8'h0F);
    rc(pin_mux_pkg::OFS_PINSTATE, 32'h0A);
    wr(pin_mux_pkg::OFS_DIGIN, 32'hFF);
    ext_val <= 8'h00;
  endtask

  task automatic t_irq;
    wr(pin_mux_pkg::OFS_IRQ_STATUS, 32'h7);
    wr(pin_mux_pkg::OFS_IRQ_MASK, 32'h1);
    for (int e = 1; e <= 2; e++)
    begin
      wr(pin_mux_pkg::OFS_EDGE, e);
      ext_val[0] <= 1'b1;
      settle;
      chk(irq, e == 1);
      chk(ext_irq_line_zero, 1'b1);
      chk(ext_irq_edge, {1'b0, e == 1, 1'b0});
      wr(pin_mux_pkg::OFS_IRQ_STATUS, 32'h1);
      ext_val[0] <= 1'b0;
      settle;
      chk(irq, e == 2);
      wr(pin_mux_pkg::OFS_IRQ_STATUS, 32'h1);
    end
    wr(pin_mux_pkg::OFS_IRQ_MASK, 32'h0);
    ext_val[0] <= 1'b1;
    settle;
    ext_val[0] <= 1'b0;
    settle;
    chk(irq, 1'b0);
    rc(pin_mux_pkg::OFS_IRQ_STATUS, 32'h1);
    wr(pin_mux_pkg::OFS_IRQ_MASK, 32'h1);
    @(negedge clk);
    chk(irq, 1'b1);
    wr(pin_mux_pkg::OFS_IRQ_STATUS, 32'h7);
    wr(pin_mux_pkg::OFS_IRQ_MASK, 32'h2);
    wr(pin_mux_pkg::OFS_EDGE, 32'hC);
    for (int s = 0; s < 2; s++)
    begin
      wr(pin_mux_pkg::OFS_ALTSEL, s << 6);
      ext_val[2] <= ~ext_val[2];
      settle;
      chk(irq, s[0]);
    end
    ext_val[2] <= 1'b1;
    settle;
    chk(ext_irq_line_one_alt, 1'b1);
    wr(pin_mux_pkg::OFS_ALTSEL, 32'h00);
    wr(pin_mux_pkg::OFS_IRQ_STATUS, 32'h7);
  endtask

  // The pin is pulsed and left low, so re-enabling its input is no change by itself
  task automatic t_wake;
    wr(pin_mux_pkg::OFS_IRQ_MASK, 32'h4);
    wr(pin_mux_pkg::OFS_DIGIN, 32'hFE);
    sleep_mode <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      ext_val[0] <= 1'b1;
      settle;
      ext_val[0] <= 1'b0;
      settle;
      chk(wake_request, s[0]);
      chk(irq, s[0]);
      wr(pin_mux_pkg::OFS_DIGIN, 32'hFF);
    end
    sleep_mode <= 1'b0;
    wr(pin_mux_pkg::OFS_IRQ_STATUS, 32'h7);
    @(negedge clk);
    chk(wake_request, 1'b0);
  endtask

  task automatic t_alt;
    ext_en <= 8'h3C;
    wr(pin_mux_pkg::OFS_ALTSEL, 32'h3C);
    for (int v = 0; v < 2; v++)
    begin
      wr(pin_mux_pkg::OFS_DATA, v ? 32'h00 : 32'hFF);
      comparator_out <= v[0];
      timer_two_pwm_out <= ~v[0];
      timer_three_pwm_out <= v[0];
      @(negedge clk);
      chk(pin_oe & 8'hC3, 8'hC3);
      chk(comparator_route_sel, 6'h01);
      chk(pin_out & 8'hC3, {v[0], v[0], 4'h0, ~v[0], v[0]});
    end
    wr(pin_mux_pkg::OFS_ALTSEL, 32'h00);
    ext_en <= 8'hFF;
  endtask

  task automatic t_crystal;
    wr(pin_mux_pkg::OFS_DIGIN, 32'hCC);
    wr(pin_mux_pkg::OFS_ALTSEL, 32'h83);
    wr(pin_mux_pkg::OFS_DIR, 32'h30);
    ext_val <= 8'h20;
    settle;
    chk(crystal_sel, 1'b1);
    chk(crystal_out_en, 1'b1);
    chk(comparator_route_sel, 6'h10);
    chk(pin_oe, 8'h00);
    chk(crystal_in_pin, 1'b1);
    chk(pulldown_b6, 1'b1);
    chk(adc_input_sel, 5'h14);
    chk(external_reset_pin, 1'b1);
    ext_val <= 8'h28;
    settle;
    chk(external_reset_pin, 1'b0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      results;
    end
  end

  initial
  begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    {comparator_out, timer_two_pwm_out, timer_three_pwm_out, sleep_mode} = 4'h0;
    ext_en = 8'hFF;
    ext_val = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_gpio;
    t_input;
    t_irq;
    t_wake;
    t_alt;
    t_crystal;
    results;
  end
endmodule
`default_nettype wire
